// ---- src/drs_pkg.sv ----
// package for the data role swap (downstream to upstream) state machine
package drs_pkg;

   // state encoding, one-hot
   typedef enum logic [8:0] {
      DRS_READY      = 9'h001,
      DRS_EVALUATE   = 9'h002,
      DRS_ACCEPT     = 9'h004,
      DRS_REFUSE     = 9'h008,
      DRS_CHANGE_UFP = 9'h010,
      DRS_SEND_REQ   = 9'h020,
      DRS_HARD_RESET = 9'h040,
      DRS_IDLE       = 9'h080,
      DRS_WAIT_READY = 9'h100
   } drs_state_e;

   // policy manager answer codes for the evaluation query
   localparam logic [1:0] DRS_EVAL_OK = 2'h1;
   localparam logic [1:0] DRS_EVAL_REJECT = 2'h2;
   localparam logic [1:0] DRS_EVAL_WAIT = 2'h3;

   // message kinds asked of the protocol layer
   localparam logic [1:0] DRS_MSG_DR_SWAP = 2'h0;
   localparam logic [1:0] DRS_MSG_ACCEPT = 2'h1;
   localparam logic [1:0] DRS_MSG_REJECT = 2'h2;
   localparam logic [1:0] DRS_MSG_WAIT = 2'h3;

   // response wait timer, in microseconds and in clk_sys cycles (125 MHz)
   localparam int DRS_CLK_MHZ = 125;
   localparam int DRS_RESP_TIME_US = 27;
   localparam int DRS_RESP_CYCLES = DRS_RESP_TIME_US * DRS_CLK_MHZ;
   localparam int DRS_TMR_W = 24;

   // data role values; DRS_ROLE_DFP is the reset value
   localparam logic DRS_ROLE_DFP = 1'b0;
   localparam logic DRS_ROLE_UFP = 1'b1;

endpackage

// ---- src/drs_timer.sv ----
// one-shot response wait timer with single-cycle expiry pulse
`timescale 1ns/1ns
module drs_timer #(
   parameter int WIDTH = 24
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic start,
   input wire logic stop,
   input wire logic [WIDTH-1:0] load,
   output logic expired
);

   typedef struct packed {
      logic run;
      logic [WIDTH-1:0] cnt;
      logic exp;
   } drs_tmr_s;

   drs_tmr_s st_reg;
   drs_tmr_s st_next;

   always_comb begin
      st_next = st_reg;
      st_next.exp = 1'b0;
      if (stop) begin
         st_next.run = 1'b0;
      end else if (start) begin
         st_next.run = 1'b1;
         st_next.cnt = load;
      end else if (st_reg.run) begin
         if (st_reg.cnt <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
            // expiry seen once, then the timer parks
            st_next.run = 1'b0;
            st_next.exp = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt - {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign expired = st_reg.exp;

endmodule

// ---- src/drs_dfp_ufp.sv ----
// data role swap state machine for a dual-role port acting as downstream
// Summary of operation
// [RULE1] machine is active only when the port is a dual-role port
// [RULE2] swap activity starts only from source-ready or sink-ready
// [RULE3] swap request received, no alternate modes: go evaluate
// [RULE4] swap request received with alternate modes: hard reset by power role
// [RULE5] local manager wants a swap: go send a swap request
// [RULE6] on evaluation entry ask the manager and wait for its answer
// [RULE7] manager approves: go to accepting
// [RULE8] manager refuses or needs more time: go to refusing
// [RULE9] on accepting entry ask protocol layer to send Accept
// [RULE10] Accept sent: go change to upstream
// [RULE11] on change entry ask manager to switch role to upstream
// [RULE12] manager confirms upstream role: go to idle as upstream and stay there
// [RULE13] on send entry request swap message and start response timer
// [RULE14] leaving send state by any path stops the response timer
// [RULE15] Reject, Wait or timeout while sending: back to ready, downstream
// [RULE16] Accept received in send state: go change to upstream
// [RULE17] refusing because swap impossible: send Reject
// [RULE18] refusing as evaluation pends: send Wait; partner retries later
// [RULE19] Reject or Wait sent: back to ready, still downstream
// [RULE20] timer length is a parameter, expiry a one-cycle event
// [RULE21] requests are entry pulses, completion from done or result inputs
`timescale 1ns/1ns
module drs_dfp_ufp #(
   parameter int RESP_CYCLES = drs_pkg::DRS_RESP_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic dual_role_port,
   input wire logic power_ready,
   input wire logic power_role_source,
   input wire logic alt_modes_active,
   input wire logic rx_dr_swap,
   input wire logic rx_accept,
   input wire logic rx_reject,
   input wire logic rx_wait,
   input wire logic tx_done,
   input wire logic tx_fail,
   input wire logic pm_swap_wanted,
   input wire logic pm_eval_valid,
   input wire logic [1:0] pm_eval_result,
   input wire logic pm_role_done,
   input wire logic hard_reset_done,
   output logic tx_req,
   output logic [1:0] tx_msg,
   output logic pm_eval_req,
   output logic pm_role_req,
   output logic source_hard_reset_req,
   output logic sink_hard_reset_req,
   output logic data_role_ufp,
   output logic swap_busy,
   output logic [8:0] state_out
);

   typedef struct packed {
      drs_pkg::drs_state_e state;
      logic tx_req;
      logic [1:0] tx_msg;
      logic eval_req;
      logic role_req;
      logic src_hr;
      logic snk_hr;
      logic role_ufp;
      logic refuse_wait;
      logic tmr_start;
      logic tmr_stop;
      logic busy;
   } drs_fsm_s;

   drs_fsm_s st_reg;
   drs_fsm_s st_next;
   logic tmr_expired;

   // entry pulse for protocol layer send request
   function automatic logic [2:0] drs_send(input logic [1:0] msg);
      drs_send = {1'b1, msg};
   endfunction

   // idle, wait-ready and ready report free; every swap state reports busy
   function automatic logic drs_busy(input drs_pkg::drs_state_e s);
      case (s)
         drs_pkg::DRS_IDLE: begin
            drs_busy = 1'b0;
         end
         drs_pkg::DRS_WAIT_READY: begin
            drs_busy = 1'b0;
         end
         drs_pkg::DRS_READY: begin
            drs_busy = 1'b0;
         end
         default: begin
            drs_busy = 1'b1;
         end
      endcase
   endfunction

   drs_timer #(
      .WIDTH(drs_pkg::DRS_TMR_W)
   ) u_resp_timer (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .start(st_reg.tmr_start),
      .stop(st_reg.tmr_stop),
      .load(RESP_CYCLES[drs_pkg::DRS_TMR_W-1:0]), // [RULE20]
      .expired(tmr_expired)
   );

   always_comb begin
      st_next = st_reg;
      // all requests are one-cycle pulses
      st_next.tx_req = 1'b0;
      st_next.eval_req = 1'b0;
      st_next.role_req = 1'b0;
      st_next.src_hr = 1'b0;
      st_next.snk_hr = 1'b0;
      st_next.tmr_start = 1'b0;
      st_next.tmr_stop = 1'b0;
      case (st_reg.state)
         drs_pkg::DRS_IDLE: begin
            // non dual-role ports never leave idle
            if (dual_role_port && !st_reg.role_ufp) begin // [RULE1]
               st_next.state = drs_pkg::DRS_WAIT_READY;
            end
         end
         drs_pkg::DRS_WAIT_READY: begin
            if (!dual_role_port) begin
               st_next.state = drs_pkg::DRS_IDLE;
            end else if (power_ready) begin // [RULE2]
               st_next.state = drs_pkg::DRS_READY;
            end
         end
         drs_pkg::DRS_READY: begin
            if (!dual_role_port || st_reg.role_ufp) begin
               st_next.state = drs_pkg::DRS_IDLE;
            end else if (!power_ready) begin // [RULE2]
               st_next.state = drs_pkg::DRS_WAIT_READY;
            end else if (rx_dr_swap && alt_modes_active) begin // [RULE4]
               st_next.state = drs_pkg::DRS_HARD_RESET;
               st_next.src_hr = power_role_source;
               st_next.snk_hr = !power_role_source;
            end else if (rx_dr_swap) begin // [RULE3]
               // partner's request beats a local one in the same cycle
               st_next.state = drs_pkg::DRS_EVALUATE;
               st_next.eval_req = 1'b1; // [RULE6] [RULE21]
            end else if (pm_swap_wanted) begin // [RULE5]
               st_next.state = drs_pkg::DRS_SEND_REQ;
               {st_next.tx_req, st_next.tx_msg} =
                  drs_send(drs_pkg::DRS_MSG_DR_SWAP); // [RULE13]
               st_next.tmr_start = 1'b1; // [RULE13]
            end
         end
         drs_pkg::DRS_EVALUATE: begin
            if (pm_eval_valid) begin // [RULE6]
               if (pm_eval_result == drs_pkg::DRS_EVAL_OK) begin // [RULE7]
                  st_next.state = drs_pkg::DRS_ACCEPT;
                  {st_next.tx_req, st_next.tx_msg} =
                     drs_send(drs_pkg::DRS_MSG_ACCEPT); // [RULE9]
               end else if (pm_eval_result == drs_pkg::DRS_EVAL_WAIT) begin
                  st_next.state = drs_pkg::DRS_REFUSE; // [RULE8]
                  st_next.refuse_wait = 1'b1;
                  {st_next.tx_req, st_next.tx_msg} =
                     drs_send(drs_pkg::DRS_MSG_WAIT); // [RULE18]
               end else begin
                  // any other answer is treated as a refusal
                  st_next.state = drs_pkg::DRS_REFUSE; // [RULE8]
                  st_next.refuse_wait = 1'b0;
                  {st_next.tx_req, st_next.tx_msg} =
                     drs_send(drs_pkg::DRS_MSG_REJECT); // [RULE17]
               end
            end
         end
         drs_pkg::DRS_ACCEPT: begin
            if (tx_done) begin // [RULE10]
               st_next.state = drs_pkg::DRS_CHANGE_UFP;
               st_next.role_req = 1'b1; // [RULE11]
            end else if (tx_fail) begin
               // accept never reached the partner: keep the role
               st_next.state = drs_pkg::DRS_WAIT_READY;
            end
         end
         drs_pkg::DRS_REFUSE: begin
            if (tx_done || tx_fail) begin // [RULE19]
               st_next.state = drs_pkg::DRS_WAIT_READY;
            end
         end
         drs_pkg::DRS_CHANGE_UFP: begin
            if (pm_role_done) begin // [RULE12]
               st_next.role_ufp = drs_pkg::DRS_ROLE_UFP;
               st_next.state = drs_pkg::DRS_IDLE;
            end
         end
         drs_pkg::DRS_SEND_REQ: begin
            if (rx_accept) begin // [RULE16]
               st_next.state = drs_pkg::DRS_CHANGE_UFP;
               st_next.role_req = 1'b1; // [RULE11]
               st_next.tmr_stop = 1'b1; // [RULE14]
            end else if (rx_reject || rx_wait || tmr_expired
                         || tx_fail) begin // [RULE15]
               st_next.state = drs_pkg::DRS_WAIT_READY;
               st_next.tmr_stop = 1'b1; // [RULE14]
            end
         end
         drs_pkg::DRS_HARD_RESET: begin
            // hard reset returns the port to the downstream role
            if (hard_reset_done) begin
               st_next.role_ufp = drs_pkg::DRS_ROLE_DFP;
               st_next.state = drs_pkg::DRS_WAIT_READY;
            end
         end
         default: begin
            st_next.state = drs_pkg::DRS_IDLE;
         end
      endcase
      // decoded from the next state so the flag leaves a flip-flop
      st_next.busy = drs_busy(st_next.state);
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         st_reg <= '0;
         st_reg.state <= drs_pkg::DRS_IDLE;
         st_reg.role_ufp <= drs_pkg::DRS_ROLE_DFP;
      end else begin
         st_reg <= st_next;
      end
   end

   // every output is taken from the state register
   assign tx_req = st_reg.tx_req;
   assign tx_msg = st_reg.tx_msg;
   assign pm_eval_req = st_reg.eval_req;
   assign pm_role_req = st_reg.role_req;
   assign source_hard_reset_req = st_reg.src_hr;
   assign sink_hard_reset_req = st_reg.snk_hr;
   assign data_role_ufp = st_reg.role_ufp;
   assign state_out = st_reg.state;
   assign swap_busy = st_reg.busy;

endmodule

// ---- tb/drs_link_model.sv ----
// protocol layer model: reports each requested message as sent or failed
`timescale 1ns/1ns
module drs_link_model (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic tx_req,
   input wire logic fail,
   input wire logic [3:0] dly,
   output logic tx_done = 1'b0,
   output logic tx_fail = 1'b0
);
   logic busy = 1'b0;
   logic [3:0] cnt = 4'h0;
   logic fin;
   assign fin = rstn && !tx_req && busy && cnt == 4'h0;
   // acts on the falling edge like the rest of the bench stimulus
   always @(negedge clk_sys) begin
      tx_done <= fin && !fail;
      tx_fail <= fin && fail;
      if (!rstn) begin
         busy <= 1'b0;
      end else if (tx_req) begin
         busy <= 1'b1;
         cnt <= dly;
      end else if (fin) begin
         busy <= 1'b0;
      end else if (busy) begin
         cnt <= cnt - 4'h1;
      end
   end
endmodule

// ---- tb/drs_chk.sv ----
// assertions on the ports of the data role swap state machine
`timescale 1ns/1ns
module drs_chk #(
   parameter int RESP_CYCLES = 20
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic power_ready,
   input wire logic dual_role_port,
   input wire logic power_role_source,
   input wire logic alt_modes_active,
   input wire logic rx_dr_swap,
   input wire logic rx_accept,
   input wire logic tx_done,
   input wire logic pm_swap_wanted,
   input wire logic pm_eval_valid,
   input wire logic [1:0] pm_eval_result,
   input wire logic pm_role_done,
   input wire logic tx_req,
   input wire logic [1:0] tx_msg,
   input wire logic pm_eval_req,
   input wire logic pm_role_req,
   input wire logic source_hard_reset_req,
   input wire logic sink_hard_reset_req,
   input wire logic data_role_ufp,
   input wire logic [8:0] state_out
);
   localparam logic [8:0] RDY = drs_pkg::DRS_READY;
   localparam logic [8:0] SND = drs_pkg::DRS_SEND_REQ;
   localparam logic [8:0] CHG = drs_pkg::DRS_CHANGE_UFP;
   logic [15:0] snd_cnt;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   always_ff @(posedge clk_sys) begin
      snd_cnt <= (!rstn || state_out != SND) ? 16'h0000 : snd_cnt + 16'h0001;
   end
   sequence s_rdy_rx;
      state_out == RDY && rx_dr_swap && dual_role_port && power_ready;
   endsequence
   a_eval_entry:
      assert property (s_rdy_rx ##0 !alt_modes_active |=> pm_eval_req &&
         state_out == drs_pkg::DRS_EVALUATE) else $error("no evaluation");
   a_hard_reset:
      assert property (s_rdy_rx ##0 alt_modes_active |=> source_hard_reset_req
         == $past(power_role_source) && sink_hard_reset_req !=
         $past(power_role_source)) else $error("wrong hard reset");
   a_send_entry:
      assert property (state_out == RDY && dual_role_port && pm_swap_wanted &&
         power_ready && !rx_dr_swap |=> tx_req &&
         tx_msg == drs_pkg::DRS_MSG_DR_SWAP && state_out == SND)
         else $error("no swap request sent");
   a_eval_answer:
      assert property (state_out == drs_pkg::DRS_EVALUATE && pm_eval_valid
         |=> tx_req && tx_msg == ($past(pm_eval_result) == 2'h0 ?
         drs_pkg::DRS_MSG_REJECT : $past(pm_eval_result)))
         else $error("wrong answer message");
   a_accept_sent:
      assert property (state_out == drs_pkg::DRS_ACCEPT && tx_done |=>
         pm_role_req && state_out == CHG) else $error("no role change");
   a_send_accept:
      assert property (state_out == SND && rx_accept |=> pm_role_req &&
         state_out == CHG) else $error("accept not taken");
   a_role_change:
      assert property (state_out == CHG && pm_role_done |=> data_role_ufp)
         else $error("role not upstream");
   a_timer_bound:
      assert property (snd_cnt <= RESP_CYCLES + 4)
         else $error("response wait too long");
endmodule
bind drs_dfp_ufp drs_chk #(
   .RESP_CYCLES(RESP_CYCLES)
) drs_chk_i (
   .clk_sys(clk_sys),
   .rstn(rstn),
   .power_ready(power_ready),
   .dual_role_port(dual_role_port),
   .power_role_source(power_role_source),
   .alt_modes_active(alt_modes_active),
   .rx_dr_swap(rx_dr_swap),
   .rx_accept(rx_accept),
   .tx_done(tx_done),
   .pm_swap_wanted(pm_swap_wanted),
   .pm_eval_valid(pm_eval_valid),
   .pm_eval_result(pm_eval_result),
   .pm_role_done(pm_role_done),
   .tx_req(tx_req),
   .tx_msg(tx_msg),
   .pm_eval_req(pm_eval_req),
   .pm_role_req(pm_role_req),
   .source_hard_reset_req(source_hard_reset_req),
   .sink_hard_reset_req(sink_hard_reset_req),
   .data_role_ufp(data_role_ufp),
   .state_out(state_out)
);

// ---- tb/testbench.sv ----
// self-checking bench for the data role swap state machine
`timescale 1ns/1ns
module testbench;
   localparam int RC = 20;
   localparam logic [8:0] RDY = drs_pkg::DRS_READY;
   localparam logic [8:0] WRD = drs_pkg::DRS_WAIT_READY;
   localparam logic [8:0] SND = drs_pkg::DRS_SEND_REQ;
   logic clk_sys = 0, rstn = 0, dual_role_port = 1, power_ready = 1;
   logic power_role_source = 1, alt_modes_active = 0, rx_dr_swap = 0;
   logic rx_accept = 0, rx_reject = 0, rx_wait = 0, pm_swap_wanted = 0;
   logic pm_eval_valid = 0, pm_role_done = 0, hard_reset_done = 0;
   logic [1:0] pm_eval_result = 2'h0;
   logic tx_done, tx_fail, tx_req, pm_eval_req, pm_role_req, swap_busy;
   logic source_hard_reset_req, sink_hard_reset_req, data_role_ufp;
   logic [1:0] tx_msg;
   logic [8:0] state_out;
   logic fail = 0;
   logic [3:0] dly = 4'h2;
   int n_fail = 0, n_checks = 0, cyc = 0;
   drs_dfp_ufp #(
      .RESP_CYCLES(RC)
   ) drs_dfp_ufp_i (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .dual_role_port(dual_role_port),
      .power_ready(power_ready),
      .power_role_source(power_role_source),
      .alt_modes_active(alt_modes_active),
      .rx_dr_swap(rx_dr_swap),
      .rx_accept(rx_accept),
      .rx_reject(rx_reject),
      .rx_wait(rx_wait),
      .tx_done(tx_done),
      .tx_fail(tx_fail),
      .pm_swap_wanted(pm_swap_wanted),
      .pm_eval_valid(pm_eval_valid),
      .pm_eval_result(pm_eval_result),
      .pm_role_done(pm_role_done),
      .hard_reset_done(hard_reset_done),
      .tx_req(tx_req),
      .tx_msg(tx_msg),
      .pm_eval_req(pm_eval_req),
      .pm_role_req(pm_role_req),
      .source_hard_reset_req(source_hard_reset_req),
      .sink_hard_reset_req(sink_hard_reset_req),
      .data_role_ufp(data_role_ufp),
      .swap_busy(swap_busy),
      .state_out(state_out)
   );
   drs_link_model drs_link_model_i (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .tx_req(tx_req),
      .fail(fail),
      .dly(dly),
      .tx_done(tx_done),
      .tx_fail(tx_fail)
   );
   initial forever #4 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc > 20000) begin
         n_fail++;
         finish_test;
      end
   end
   task finish_test;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task wait_st(input logic [8:0] s);
      for (int i = 0; i < RC + 20 && state_out !== s; i++) tick(1);
   endtask
   task rst;
      rstn = 0;
      tick(2);
      rstn = 1;
      wait_st(RDY);
   endtask
   task s_accept;
      rx_dr_swap = 1;
      tick(1);
      rx_dr_swap = 0;
      chk({pm_eval_req, state_out}, {1'b1, drs_pkg::DRS_EVALUATE});
      chk(swap_busy, 1);
      pm_eval_valid = 1;
      pm_eval_result = drs_pkg::DRS_EVAL_OK;
      tick(1);
      pm_eval_valid = 0;
      chk({tx_req, tx_msg}, {1'b1, drs_pkg::DRS_MSG_ACCEPT});
      wait_st(drs_pkg::DRS_CHANGE_UFP);
      chk({pm_role_req, data_role_ufp}, 2'h2);
      pm_role_done = 1;
      tick(1);
      pm_role_done = 0;
      chk(data_role_ufp, 1);
      rst;
   endtask
   task s_refuse(input logic [1:0] r, input logic [1:0] m, input logic f);
      fail = f;
      rx_dr_swap = 1;
      tick(1);
      rx_dr_swap = 0;
      pm_eval_valid = 1;
      pm_eval_result = r;
      tick(1);
      pm_eval_valid = 0;
      chk({tx_req, tx_msg}, {1'b1, m});
      wait_st(RDY);
      chk({data_role_ufp, state_out}, {1'b0, RDY});
      chk(swap_busy, 0);
      fail = 0;
   endtask
   task s_power;
      power_ready = 0;
      tick(1);
      rx_dr_swap = 1;
      pm_swap_wanted = 1;
      tick(1);
      {rx_dr_swap, pm_swap_wanted} = 2'h0;
      chk({pm_eval_req, tx_req, state_out}, {2'h0, WRD});
      power_ready = 1;
      wait_st(RDY);
      chk(state_out, RDY);
   endtask
   task s_hard(input logic s);
      power_role_source = s;
      alt_modes_active = 1;
      rx_dr_swap = 1;
      tick(1);
      rx_dr_swap = 0;
      alt_modes_active = 0;
      chk({source_hard_reset_req, sink_hard_reset_req}, {s, !s});
      hard_reset_done = 1;
      tick(1);
      hard_reset_done = 0;
      wait_st(RDY);
      chk({data_role_ufp, state_out}, {1'b0, RDY});
      power_role_source = 1;
   endtask
   task s_send(input int k);
      int t;
      pm_swap_wanted = 1;
      tick(1);
      pm_swap_wanted = 0;
      t = cyc;
      chk({tx_req, tx_msg, state_out}, {3'h4, SND});
      // answer only after the protocol layer has reported the request sent
      tick(4);
      rx_reject = (k == 0);
      rx_wait = (k == 1);
      rx_accept = (k == 2);
      tick(1);
      {rx_reject, rx_wait, rx_accept} = 3'h0;
      if (k == 2) begin
         chk(state_out, drs_pkg::DRS_CHANGE_UFP);
         rst;
      end else begin
         wait_st(RDY);
         chk({data_role_ufp, state_out}, {1'b0, RDY});
         if (k == 3) chk(cyc - t >= RC, 1);
      end
   endtask
   task s_idle;
      dual_role_port = 0;
      rst;
      rx_dr_swap = 1;
      tick(1);
      rx_dr_swap = 0;
      chk({pm_eval_req, state_out}, {1'b0, drs_pkg::DRS_IDLE});
      dual_role_port = 1;
      rst;
   endtask
   initial begin
      rst;
      s_accept;
      s_refuse(drs_pkg::DRS_EVAL_REJECT, drs_pkg::DRS_MSG_REJECT, 0);
      s_refuse(drs_pkg::DRS_EVAL_WAIT, drs_pkg::DRS_MSG_WAIT, 0);
      s_refuse(2'h0, drs_pkg::DRS_MSG_REJECT, 0);
      s_refuse(drs_pkg::DRS_EVAL_REJECT, drs_pkg::DRS_MSG_REJECT, 1);
      s_hard(1);
      s_hard(0);
      s_power;
      for (int k = 0; k < 4; k++) s_send(k);
      s_idle;
      finish_test;
   end
endmodule
